// file: rtl/second_timer.sv
// second timer: 16-bit up-counter, one compare channel, output path, shadows
// assumes all control and event inputs are synchronous to CLK_SYS
// Contract
// - timer mode 00 counts module clock through prescaler and optional divide-by-256.
// - divider code n divides by 2**n; extra stage adds factor 256.
// - prescaler held cleared whenever the run flag is zero.
// - counter mode steps on soft pulse (01), rising (10), falling (11) pin edge.
// - counts up only, clears after period match; period is value plus one.
// - single-shot clears run flag when the current period ends.
// - selected first-timer event sets the run flag.
// - trigger select picks none, channel compares, any compare, period, zero-up, hall.
// - direction select: 00 no action, 01 up, 10 down, 11 either.
// - equality compare against active value; shadow copied only on transfer strobe.
// - compare-match event raised on equality regardless of state bit.
// - software can force the state bit to one or zero.
// - hardware changes the state bit only while running.
// - state bit set on next count clock after compare match.
// - state bit cleared on next count clock after zero match without compare.
// - separate bits choose active state for internal line and pin source.
// - pin signal active only when modulation enabled and source active.
// - trap state with trap enable forces pin signal passive.
// - pin shows passive level when passive, inverse when active.
// - passive level written to shadow, applied on transfer, read back active.
// - shadow enable set and cleared by separate one-writes.
// - strobe while stopped, or enable with period match while running; clears enable.
// - period writes reach shadow; reads return active period.
// - run flag set and cleared by requests; never set with zero period (code sets it on a request or start event whatever the period).
// - counter writes ignored while running, applied at once while stopped.
// - zero-match indication whenever counter equals zero.
`timescale 1ns/10ps
`default_nettype none
module second_timer (
	// clock and reset
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	// mode configuration
	input  wire logic [1:0]  COUNT_INPUT_SELECT,
	input  wire logic [2:0]  CLOCK_DIVIDER_SELECT,
	input  wire logic        EXTRA_DIVIDE_ENABLE,
	input  wire logic        SINGLE_SHOT_ENABLE,
	input  wire logic [2:0]  SYNC_TRIGGER_SELECT,
	input  wire logic [1:0]  SYNC_DIRECTION_SELECT,
	input  wire logic        INTERNAL_LINE_STATE_SELECT,
	input  wire logic        PIN_SOURCE_STATE_SELECT,
	input  wire logic        PIN_MODULATION_ENABLE,
	input  wire logic        TRAP_OUTPUT_ENABLE,
	// software action pulses
	input  wire logic        RUN_SET_REQUEST,
	input  wire logic        RUN_CLEAR_REQUEST,
	input  wire logic        SOFT_COUNT_PULSE,
	input  wire logic        SHADOW_ENABLE_SET,
	input  wire logic        SHADOW_ENABLE_CLEAR,
	input  wire logic        STATE_SOFT_SET,
	input  wire logic        STATE_SOFT_CLEAR,
	// software value writes
	input  wire logic        PERIOD_WR,
	input  wire logic [15:0] PERIOD_WDATA,
	input  wire logic        COMPARE_WR,
	input  wire logic [15:0] COMPARE_WDATA,
	input  wire logic        COUNTER_WR,
	input  wire logic [15:0] COUNTER_WDATA,
	input  wire logic        PASSIVE_WR,
	input  wire logic        PASSIVE_WDATA,
	// first timer events
	input  wire logic        FIRST_TIMER_COMPARE_CH0,
	input  wire logic        FIRST_TIMER_COMPARE_CH1,
	input  wire logic        FIRST_TIMER_COMPARE_CH2,
	input  wire logic        FIRST_TIMER_PERIOD_MATCH,
	input  wire logic        FIRST_TIMER_ZERO_MATCH,
	input  wire logic        FIRST_TIMER_COUNT_DIRECTION,
	input  wire logic        HALL_STATE_CHANGE,
	// trap and pin inputs
	input  wire logic        TRAP_STATE,
	input  wire logic        EXTERNAL_COUNT_INPUT,
	// status and read-back
	output logic [15:0]      COUNTER_VALUE,
	output logic [15:0]      ACTIVE_PERIOD_VALUE,
	output logic [15:0]      ACTIVE_COMPARE_VALUE,
	output logic [15:0]      COMPARE_VALUE_SHADOW,
	output logic             PASSIVE_LEVEL_BIT,
	output logic             RUN_FLAG,
	output logic             SHADOW_TRANSFER_ENABLE,
	output logic             COMPARE_STATE_BIT,
	// events
	output logic             ZERO_MATCH,
	output logic             PERIOD_MATCH,
	output logic             COMPARE_MATCH_EVENT,
	output logic             SHADOW_TRANSFER_STROBE,
	output logic             COUNT_STEP,
	// modulation outputs
	output logic             INTERNAL_MODULATION_LINE,
	output logic             COMPARE_OUTPUT_PIN
);
	logic [15:0] counter_q;
	logic [15:0] counter_d;
	logic [15:0] period_q;
	logic [15:0] period_d;
	logic [15:0] period_sh_q;
	logic [15:0] compare_q;
	logic [15:0] compare_d;
	logic [15:0] compare_sh_q;
	logic        psl_q;
	logic        psl_d;
	logic        psl_sh_q;
	logic        run_q;
	logic        run_d;
	logic        ste_q;
	logic        ste_d;
	logic        state_q;
	logic        state_d;
	logic        pin_q;
	logic        pin_d;

	count_step_if step_bus ();

	count_step_gen u_step (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.cs    (step_bus.gen)
	);

	// first-timer event chosen by the trigger select code
	function automatic logic trig_event(input logic [2:0] sel, input logic c0,
		input logic c1, input logic c2, input logic pm, input logic zm,
		input logic dir, input logic hall);
		case (sel)
			second_timer_pkg::TRIG_CH0:    trig_event = c0;
			second_timer_pkg::TRIG_CH1:    trig_event = c1;
			second_timer_pkg::TRIG_CH2:    trig_event = c2;
			second_timer_pkg::TRIG_ANY_CH: trig_event = c0 | c1 | c2;
			second_timer_pkg::TRIG_PERIOD: trig_event = pm;
			second_timer_pkg::TRIG_ZERO:
				trig_event = zm & (dir == second_timer_pkg::DIR_COUNT_UP);
			second_timer_pkg::TRIG_HALL:   trig_event = hall;
			default:                       trig_event = 1'b0;
		endcase
	endfunction : trig_event

	// direction qualifier for the start event
	function automatic logic dir_ok(input logic [1:0] sel, input logic dir);
		case (sel)
			second_timer_pkg::DIR_UP:   dir_ok = dir == second_timer_pkg::DIR_COUNT_UP;
			second_timer_pkg::DIR_DOWN: dir_ok = dir == second_timer_pkg::DIR_COUNT_DOWN;
			second_timer_pkg::DIR_BOTH: dir_ok = 1'b1;
			default:                    dir_ok = 1'b0;
		endcase
	endfunction : dir_ok

	// one state-select decode for both the internal line and the pin source
	function automatic logic state_active(input logic state, input logic sel);
		state_active = state == sel;
	endfunction : state_active

	assign step_bus.run        = run_q;
	assign step_bus.in_sel     = second_timer_pkg::count_sel_t'(COUNT_INPUT_SELECT);
	assign step_bus.clk_sel    = CLOCK_DIVIDER_SELECT;
	assign step_bus.extra_div  = EXTRA_DIVIDE_ENABLE;
	assign step_bus.soft_count = SOFT_COUNT_PULSE;
	assign step_bus.ext_in     = EXTERNAL_COUNT_INPUT;

	wire step       = step_bus.step;
	// match decodes; each lasts as long as the counter holds its value
	wire zm         = counter_q == second_timer_pkg::COUNTER_RST;
	wire pm         = counter_q == period_q;
	wire cm         = counter_q == compare_q;
	wire trig_hit   = trig_event(SYNC_TRIGGER_SELECT, FIRST_TIMER_COMPARE_CH0,
		FIRST_TIMER_COMPARE_CH1, FIRST_TIMER_COMPARE_CH2, FIRST_TIMER_PERIOD_MATCH,
		FIRST_TIMER_ZERO_MATCH, FIRST_TIMER_COUNT_DIRECTION, HALL_STATE_CHANGE);
	wire dir_hit    = dir_ok(SYNC_DIRECTION_SELECT, FIRST_TIMER_COUNT_DIRECTION);
	wire sync_start = trig_hit & dir_hit;

	// strobe is a level; transfer itself waits for a count step while running
	// limitation: an enable set while stopped is cleared at the next clock
	wire strobe     = ~run_q | (ste_q & pm & run_q);
	wire transfer   = ~run_q | (ste_q & pm & step);
	wire ss_stop    = SINGLE_SHOT_ENABLE & pm & step;
	wire run_set    = RUN_SET_REQUEST | sync_start;
	// a running counter write is dropped, not held over
	wire cnt_load   = ~run_q & COUNTER_WR;
	wire cnt_wrap   = step & pm;
	// hardware moves the state bit only on a running count step
	wire hw_set     = run_q & step & cm;
	wire hw_clr     = run_q & step & zm;
	wire trap_block = TRAP_STATE & TRAP_OUTPUT_ENABLE;

	// set wins over any clear in the same cycle
	assign run_d = run_set ? 1'b1 : (RUN_CLEAR_REQUEST | ss_stop) ? 1'b0 : run_q;

	// write beats wrap, wrap beats increment
	always_comb begin
		if (cnt_load)
			counter_d = COUNTER_WDATA;
		else if (cnt_wrap)
			counter_d = second_timer_pkg::COUNTER_RST;
		else if (step)
			counter_d = counter_q + second_timer_pkg::COUNTER_ONE;
		else
			counter_d = counter_q;
	end

	assign period_d  = transfer ? period_sh_q : period_q;
	assign compare_d = transfer ? compare_sh_q : compare_q;
	assign psl_d     = transfer ? psl_sh_q : psl_q;

	// an explicit set beats both the clear request and the auto-clear
	assign ste_d = SHADOW_ENABLE_SET ? 1'b1
		: (SHADOW_ENABLE_CLEAR | transfer) ? 1'b0 : ste_q;

	// software forcing overrides the hardware switching rule
	always_comb begin
		if (STATE_SOFT_SET)
			state_d = 1'b1;
		else if (STATE_SOFT_CLEAR)
			state_d = 1'b0;
		else if (hw_set)
			state_d = 1'b1;
		else if (hw_clr)
			state_d = 1'b0;
		else
			state_d = state_q;
	end

	// trap gating sits ahead of the level select, so polarity still holds
	wire pin_src  = state_active(state_q, PIN_SOURCE_STATE_SELECT);
	wire pin_act  = PIN_MODULATION_ENABLE & pin_src & ~trap_block;
	assign pin_d  = pin_act ? ~psl_q : psl_q;

	// counter kept on its own; a running write never reaches it
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			counter_q <= second_timer_pkg::COUNTER_RST;
		end else begin
			counter_q <= counter_d;
		end
	end

	// software shadows take every write, running or not
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			period_sh_q  <= second_timer_pkg::PERIOD_RST;
			compare_sh_q <= second_timer_pkg::COMPARE_RST;
			psl_sh_q     <= second_timer_pkg::BIT_RST;
		end else begin
			if (PERIOD_WR)
				period_sh_q <= PERIOD_WDATA;
			if (COMPARE_WR)
				compare_sh_q <= COMPARE_WDATA;
			if (PASSIVE_WR)
				psl_sh_q <= PASSIVE_WDATA;
		end
	end

	// applied values move only through the transfer selects
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			period_q  <= second_timer_pkg::PERIOD_RST;
			compare_q <= second_timer_pkg::COMPARE_RST;
			psl_q     <= second_timer_pkg::BIT_RST;
		end else begin
			period_q  <= period_d;
			compare_q <= compare_d;
			psl_q     <= psl_d;
		end
	end

	// run and transfer-enable flags
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			run_q <= second_timer_pkg::BIT_RST;
			ste_q <= second_timer_pkg::BIT_RST;
		end else begin
			run_q <= run_d;
			ste_q <= ste_d;
		end
	end

	// pin registered so a select or trap change cannot glitch the pad
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_q <= second_timer_pkg::BIT_RST;
			pin_q   <= second_timer_pkg::BIT_RST;
		end else begin
			state_q <= state_d;
			pin_q   <= pin_d;
		end
	end

	assign COUNTER_VALUE            = counter_q;
	assign ACTIVE_PERIOD_VALUE      = period_q;
	assign ACTIVE_COMPARE_VALUE     = compare_q;
	assign COMPARE_VALUE_SHADOW     = compare_sh_q;
	assign PASSIVE_LEVEL_BIT        = psl_q;
	assign RUN_FLAG                 = run_q;
	assign SHADOW_TRANSFER_ENABLE   = ste_q;
	assign COMPARE_STATE_BIT        = state_q;
	assign ZERO_MATCH               = zm;
	assign PERIOD_MATCH             = pm;
	assign COMPARE_MATCH_EVENT      = cm;
	assign SHADOW_TRANSFER_STROBE   = strobe;
	assign COUNT_STEP               = step;
	assign INTERNAL_MODULATION_LINE = state_active(state_q,
		INTERNAL_LINE_STATE_SELECT);
	assign COMPARE_OUTPUT_PIN       = pin_q;
endmodule : second_timer
`default_nettype wire

// file: include/second_timer_pkg.sv
// constants shared by the second timer core and its count-step generator
// assumes a single module clock; no bus, all controls are plain ports
`default_nettype none
package second_timer_pkg;
	localparam int          CNT_W         = 16;
	localparam int          PRESC_W       = 15;
	localparam logic [15:0] COUNTER_RST   = 16'h0000;
	localparam logic [15:0] PERIOD_RST    = 16'h0000;
	localparam logic [15:0] COMPARE_RST   = 16'h0000;
	localparam logic [14:0] PRESC_RST     = 15'h0000;
	localparam logic [14:0] PRESC_ONE     = 15'h0001;
	localparam logic [15:0] COUNTER_ONE   = 16'h0001;
	localparam logic [3:0]  EXTRA_DIV_LOG = 4'h8;
	localparam logic        BIT_RST       = 1'h0;

	// count input select
	typedef enum logic [1:0] {
		SEL_TIMER = 2'h0,
		SEL_SOFT  = 2'h1,
		SEL_RISE  = 2'h2,
		SEL_FALL  = 2'h3
	} count_sel_t;

	// start event select
	typedef enum logic [2:0] {
		TRIG_NONE   = 3'h0,
		TRIG_CH0    = 3'h1,
		TRIG_CH1    = 3'h2,
		TRIG_CH2    = 3'h3,
		TRIG_ANY_CH = 3'h4,
		TRIG_PERIOD = 3'h5,
		TRIG_ZERO   = 3'h6,
		TRIG_HALL   = 3'h7
	} trig_sel_t;

	// start event direction qualifier
	typedef enum logic [1:0] {
		DIR_NONE = 2'h0,
		DIR_UP   = 2'h1,
		DIR_DOWN = 2'h2,
		DIR_BOTH = 2'h3
	} dir_sel_t;

	localparam logic DIR_COUNT_UP   = 1'b0;
	localparam logic DIR_COUNT_DOWN = 1'b1;
endpackage : second_timer_pkg
`default_nettype wire

// file: include/count_step_if.sv
// carrier between the timer core and its count-step generator
// assumes both ends sit in the module clock domain
`timescale 1ns/10ps
`default_nettype none
interface count_step_if;
	logic                            run;
	second_timer_pkg::count_sel_t    in_sel;
	logic [2:0]                      clk_sel;
	logic                            extra_div;
	logic                            soft_count;
	logic                            ext_in;
	logic                            step;

	modport core (output run, output in_sel, output clk_sel, output extra_div,
		output soft_count, output ext_in, input step);
	modport gen (input run, input in_sel, input clk_sel, input extra_div,
		input soft_count, input ext_in, output step);
endinterface : count_step_if
`default_nettype wire

// file: rtl/count_step_gen.sv
// count-step generator: prescaler in timer mode, soft or pin edges in counter mode
// assumes the external count input may be asynchronous; it is synchronised here
`timescale 1ns/10ps
`default_nettype none
module count_step_gen (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	// core side
	count_step_if.gen  cs
);
	logic [14:0] presc_q;
	logic [14:0] presc_d;
	logic        sync1_q;
	logic        sync2_q;
	logic        prev_q;

	// all-ones mask of the division factor, 2**(n + 8*extra) - 1
	function automatic logic [14:0] div_mask(input logic [2:0] n, input logic extra);
		logic [3:0] sh;
		sh = {1'b0, n} + (extra ? second_timer_pkg::EXTRA_DIV_LOG : 4'h0);
		div_mask = 15'((16'h0001 << sh) - 16'h0001);
	endfunction : div_mask

	wire [14:0] mask     = div_mask(cs.clk_sel, cs.extra_div);
	wire        presc_tk = (presc_q & mask) == mask;
	wire        rise     = sync2_q & ~prev_q;
	wire        fall     = ~sync2_q & prev_q;

	// held cleared while stopped so the first period is always full length
	assign presc_d = cs.run ? presc_q + second_timer_pkg::PRESC_ONE
		: second_timer_pkg::PRESC_RST;

	always_comb begin
		case (cs.in_sel)
			second_timer_pkg::SEL_TIMER: cs.step = cs.run & presc_tk;
			second_timer_pkg::SEL_SOFT:  cs.step = cs.run & cs.soft_count;
			second_timer_pkg::SEL_RISE:  cs.step = cs.run & rise;
			second_timer_pkg::SEL_FALL:  cs.step = cs.run & fall;
			default:                     cs.step = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_q <= second_timer_pkg::PRESC_RST;
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
		end else begin
			presc_q <= presc_d;
			sync1_q <= cs.ext_in;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end
endmodule : count_step_gen
`default_nettype wire

// file: bench/second_timer_sva.sv
// checker for the second timer: count, compare, shadow and pin timing at the ports
// assumes it is bound to second_timer and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
module second_timer_sva (
	// clock and reset
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	// controls
	input wire logic        RUN_SET_REQUEST,
	input wire logic        RUN_CLEAR_REQUEST,
	input wire logic        COUNTER_WR,
	input wire logic        STATE_SOFT_SET,
	input wire logic        STATE_SOFT_CLEAR,
	input wire logic        SINGLE_SHOT_ENABLE,
	input wire logic [2:0]  SYNC_TRIGGER_SELECT,
	input wire logic        INTERNAL_LINE_STATE_SELECT,
	input wire logic        PIN_SOURCE_STATE_SELECT,
	input wire logic        PIN_MODULATION_ENABLE,
	input wire logic        TRAP_OUTPUT_ENABLE,
	input wire logic        TRAP_STATE,
	// observed
	input wire logic [15:0] COUNTER_VALUE,
	input wire logic [15:0] ACTIVE_COMPARE_VALUE,
	input wire logic [15:0] COMPARE_VALUE_SHADOW,
	input wire logic        PASSIVE_LEVEL_BIT,
	input wire logic        RUN_FLAG,
	input wire logic        SHADOW_TRANSFER_ENABLE,
	input wire logic        COMPARE_STATE_BIT,
	input wire logic        ZERO_MATCH,
	input wire logic        PERIOD_MATCH,
	input wire logic        COMPARE_MATCH_EVENT,
	input wire logic        SHADOW_TRANSFER_STROBE,
	input wire logic        COUNT_STEP,
	input wire logic        INTERNAL_MODULATION_LINE,
	input wire logic        COMPARE_OUTPUT_PIN
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	logic pin_next;
	logic step_run;
	logic seen_q;
	assign pin_next = PASSIVE_LEVEL_BIT ^ (PIN_MODULATION_ENABLE
		& (COMPARE_STATE_BIT == PIN_SOURCE_STATE_SELECT) & ~(TRAP_STATE & TRAP_OUTPUT_ENABLE));
	assign step_run = RUN_FLAG & COUNT_STEP;
	// the pin check needs one edge out of reset before $past means anything
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) seen_q <= 1'b0;
		else seen_q <= 1'b1;
	end
	a_zero_flag: assert property (ZERO_MATCH == (COUNTER_VALUE == 16'h0000))
		else $error("zero match disagrees with counter");
	a_count_up: assert property (step_run & !PERIOD_MATCH & !RUN_CLEAR_REQUEST
		|=> COUNTER_VALUE == $past(COUNTER_VALUE) + 16'h0001) else $error("counter missed a step");
	a_period_wrap: assert property (step_run & PERIOD_MATCH & !RUN_CLEAR_REQUEST
		|=> COUNTER_VALUE == 16'h0000) else $error("counter did not wrap");
	a_stop_hold: assert property (!RUN_FLAG & !COUNTER_WR |=> $stable(COUNTER_VALUE))
		else $error("counter moved while stopped");
	a_strobe_rule: assert property (SHADOW_TRANSFER_STROBE
		== (!RUN_FLAG | (SHADOW_TRANSFER_ENABLE & PERIOD_MATCH))) else $error("strobe wrong");
	a_stopped_copy: assert property (!RUN_FLAG
		|=> ACTIVE_COMPARE_VALUE == $past(COMPARE_VALUE_SHADOW)) else $error("no copy");
	a_state_set: assert property (step_run & COMPARE_MATCH_EVENT & !STATE_SOFT_CLEAR
		|=> COMPARE_STATE_BIT) else $error("state bit not set");
	a_state_clear: assert property (step_run & ZERO_MATCH & !COMPARE_MATCH_EVENT
		& !STATE_SOFT_SET |=> !COMPARE_STATE_BIT) else $error("state bit not cleared");
	a_state_hold: assert property (!RUN_FLAG & !STATE_SOFT_SET & !STATE_SOFT_CLEAR
		|=> $stable(COMPARE_STATE_BIT)) else $error("state bit moved while stopped");
	a_pin_level: assert property (seen_q |-> COMPARE_OUTPUT_PIN == $past(pin_next))
		else $error("pin level wrong");
	a_line_select: assert property (INTERNAL_MODULATION_LINE
		== (COMPARE_STATE_BIT == INTERNAL_LINE_STATE_SELECT)) else $error("line wrong");
	a_single_shot: assert property (step_run & PERIOD_MATCH & SINGLE_SHOT_ENABLE
		& !RUN_SET_REQUEST & SYNC_TRIGGER_SELECT == 3'h0 |=> !RUN_FLAG) else $error("no stop");
	cover property (step_run & PERIOD_MATCH);
	cover property (step_run & PERIOD_MATCH & SHADOW_TRANSFER_ENABLE);
	cover property (TRAP_STATE & TRAP_OUTPUT_ENABLE & PIN_MODULATION_ENABLE);
endmodule : second_timer_sva
bind second_timer second_timer_sva chk (.*);
`default_nettype wire

// file: bench/count_pin_src.sv
// far-side pulse source on the external count input
// assumes the bench calls toggle from its falling-edge driving thread
`timescale 1ns/10ps
`default_nettype none
module count_pin_src (
	// clock
	input  wire logic CLK_SYS,
	// pin
	output var logic  EXTERNAL_COUNT_INPUT
);
	initial EXTERNAL_COUNT_INPUT = 1'b0;
	// edges four cycles apart so each one outlasts the synchroniser
	task automatic toggle(input int n);
		for (int i = 0; i < n; i++) begin
			EXTERNAL_COUNT_INPUT = ~EXTERNAL_COUNT_INPUT;
			repeat (4) @(negedge CLK_SYS);
		end
	endtask : toggle
endmodule : count_pin_src
`default_nettype wire

// file: bench/second_timer_bench.sv
// self-checking bench for the second timer, driven at the falling clock edge
// assumes the checker is bound in and the pin source models the far side
`timescale 1ns/10ps
`default_nettype none
module second_timer_bench;
	localparam logic [5:0] EV_MAP [8] = '{6'h3f, 6'h01, 6'h02, 6'h04, 6'h02, 6'h08, 6'h10, 6'h20};
	logic        CLK_SYS, RST_N, EXTRA_DIVIDE_ENABLE, SINGLE_SHOT_ENABLE, TRAP_STATE;
	logic [1:0]  COUNT_INPUT_SELECT, SYNC_DIRECTION_SELECT;
	logic [2:0]  CLOCK_DIVIDER_SELECT, SYNC_TRIGGER_SELECT;
	logic [5:0]  ev;
	logic [15:0] PERIOD_WDATA, COMPARE_WDATA, COUNTER_WDATA, COUNTER_VALUE;
	logic [15:0] ACTIVE_PERIOD_VALUE, ACTIVE_COMPARE_VALUE, COMPARE_VALUE_SHADOW;
	logic        INTERNAL_LINE_STATE_SELECT, PIN_SOURCE_STATE_SELECT, PIN_MODULATION_ENABLE;
	logic        TRAP_OUTPUT_ENABLE, RUN_SET_REQUEST, RUN_CLEAR_REQUEST, SOFT_COUNT_PULSE;
	logic        SHADOW_ENABLE_SET, SHADOW_ENABLE_CLEAR, STATE_SOFT_SET, STATE_SOFT_CLEAR;
	logic        PERIOD_WR, COMPARE_WR, COUNTER_WR, PASSIVE_WR, PASSIVE_WDATA;
	logic        FIRST_TIMER_COMPARE_CH0, FIRST_TIMER_COMPARE_CH1, FIRST_TIMER_COMPARE_CH2;
	logic        FIRST_TIMER_PERIOD_MATCH, FIRST_TIMER_ZERO_MATCH, HALL_STATE_CHANGE;
	logic        FIRST_TIMER_COUNT_DIRECTION, EXTERNAL_COUNT_INPUT, PASSIVE_LEVEL_BIT;
	logic        RUN_FLAG, SHADOW_TRANSFER_ENABLE, COMPARE_STATE_BIT, ZERO_MATCH;
	logic        PERIOD_MATCH, COMPARE_MATCH_EVENT, SHADOW_TRANSFER_STROBE, COUNT_STEP;
	logic        INTERNAL_MODULATION_LINE, COMPARE_OUTPUT_PIN;
	int          fails, check_count, cycles;
	assign {HALL_STATE_CHANGE, FIRST_TIMER_ZERO_MATCH, FIRST_TIMER_PERIOD_MATCH,
		FIRST_TIMER_COMPARE_CH2, FIRST_TIMER_COMPARE_CH1, FIRST_TIMER_COMPARE_CH0} = ev;
	second_timer DUT (.*);
	count_pin_src pin (.CLK_SYS(CLK_SYS), .EXTERNAL_COUNT_INPUT(EXTERNAL_COUNT_INPUT));
	initial CLK_SYS = 1'b0;
	always #2 CLK_SYS = ~CLK_SYS;
	task automatic cyc(input int n);
		repeat (n) @(negedge CLK_SYS);
	endtask : cyc
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask : pulse
	task automatic wr16(ref logic w, ref logic [15:0] d, input logic [15:0] v);
		d = v;
		pulse(w);
	endtask : wr16
	task automatic restart();
		pulse(RUN_CLEAR_REQUEST);
		pulse(RUN_SET_REQUEST);
	endtask : restart
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	always @(posedge CLK_SYS) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		{RST_N, EXTRA_DIVIDE_ENABLE, SINGLE_SHOT_ENABLE, TRAP_STATE, COUNT_INPUT_SELECT, ev,
			SYNC_DIRECTION_SELECT, CLOCK_DIVIDER_SELECT, SYNC_TRIGGER_SELECT, PERIOD_WDATA,
			COMPARE_WDATA, COUNTER_WDATA, INTERNAL_LINE_STATE_SELECT, PIN_SOURCE_STATE_SELECT,
			PIN_MODULATION_ENABLE, TRAP_OUTPUT_ENABLE, RUN_SET_REQUEST, RUN_CLEAR_REQUEST,
			SOFT_COUNT_PULSE, SHADOW_ENABLE_SET, SHADOW_ENABLE_CLEAR, STATE_SOFT_SET,
			STATE_SOFT_CLEAR, PERIOD_WR, COMPARE_WR, COUNTER_WR, PASSIVE_WR, PASSIVE_WDATA,
			FIRST_TIMER_COUNT_DIRECTION} = '0;
		cyc(4);
		RST_N = 1'b1;
		cyc(1);
		check("zero match", 16'h0001, ZERO_MATCH);
		wr16(PERIOD_WR, PERIOD_WDATA, 16'h0002);
		wr16(COMPARE_WR, COMPARE_WDATA, 16'h0001);
		cyc(1);
		check("period", 16'h0002, ACTIVE_PERIOD_VALUE);
		pulse(RUN_SET_REQUEST);
		for (int i = 0; i < 7; i++) begin
			check("count", 16'(i % 3), COUNTER_VALUE);
			check("match", 16'(i % 3 == 1), COMPARE_MATCH_EVENT);
			check("period match", 16'(i % 3 == 2), PERIOD_MATCH);
			check("state", 16'(i != 0 && i % 3 != 1), COMPARE_STATE_BIT);
			cyc(1);
		end
		// phase chosen so the enable clear never lands on a period match
		wr16(COMPARE_WR, COMPARE_WDATA, 16'h0002);
		wr16(PERIOD_WR, PERIOD_WDATA, 16'h0004);
		PASSIVE_WDATA = 1'b1;
		pulse(PASSIVE_WR);
		cyc(1);
		pulse(SHADOW_ENABLE_SET);
		pulse(SHADOW_ENABLE_CLEAR);
		cyc(4);
		check("held period", 16'h0002, ACTIVE_PERIOD_VALUE);
		check("held level", 16'h0000, PASSIVE_LEVEL_BIT);
		check("shadow cmp", 16'h0002, COMPARE_VALUE_SHADOW);
		check("strobe running", 16'h0000, SHADOW_TRANSFER_STROBE);
		pulse(SHADOW_ENABLE_SET);
		check("enable", 16'h0001, SHADOW_TRANSFER_ENABLE);
		cyc(3);
		check("new period", 16'h0004, ACTIVE_PERIOD_VALUE);
		check("new compare", 16'h0002, ACTIVE_COMPARE_VALUE);
		check("new level", 16'h0001, PASSIVE_LEVEL_BIT);
		check("enable off", 16'h0000, SHADOW_TRANSFER_ENABLE);
		SINGLE_SHOT_ENABLE = 1'b1;
		cyc(8);
		check("one shot run", 16'h0000, RUN_FLAG);
		check("one shot count", 16'h0000, COUNTER_VALUE);
		check("strobe stopped", 16'h0001, SHADOW_TRANSFER_STROBE);
		SINGLE_SHOT_ENABLE = 1'b0;
		wr16(COUNTER_WR, COUNTER_WDATA, 16'h0005);
		check("stopped write", 16'h0005, COUNTER_VALUE);
		pulse(RUN_SET_REQUEST);
		wr16(COUNTER_WR, COUNTER_WDATA, 16'h0000);
		check("running write", 16'h0006, COUNTER_VALUE);
		pulse(RUN_CLEAR_REQUEST);
		wr16(PERIOD_WR, PERIOD_WDATA, 16'hffff);
		for (int k = 0; k < 9; k++) begin
			int steps;
			CLOCK_DIVIDER_SELECT = 3'(k % 8);
			EXTRA_DIVIDE_ENABLE = (k == 8);
			steps = 0;
			restart();
			repeat (4 << (k % 8 + 8 * (k == 8))) begin
				steps += COUNT_STEP;
				cyc(1);
			end
			check("steps", 16'h0004, 16'(steps));
		end
		EXTRA_DIVIDE_ENABLE = 1'b0;
		for (int m = 1; m < 4; m++) begin
			pulse(RUN_CLEAR_REQUEST);
			wr16(COUNTER_WR, COUNTER_WDATA, 16'h0000);
			COUNT_INPUT_SELECT = 2'(m);
			pulse(RUN_SET_REQUEST);
			// pin starts low for rising and high for falling, so the wrong edge gives two
			if (m == 1)
				repeat (3) begin
					pulse(SOFT_COUNT_PULSE);
					cyc(1);
				end
			else
				pin.toggle(5);
			cyc(4);
			check("events", 16'h0003, COUNTER_VALUE);
		end
		COUNT_INPUT_SELECT = 2'h0;
		for (int i = 0; i < 32; i++) begin
			logic want;
			pulse(RUN_CLEAR_REQUEST);
			SYNC_TRIGGER_SELECT = 3'(i / 4);
			SYNC_DIRECTION_SELECT = 2'(i % 4);
			FIRST_TIMER_COUNT_DIRECTION = (i % 4 == 2);
			want = (i / 4 != 0) && (i % 4 != 0) && !(i / 4 == 6 && i % 4 == 2);
			ev = EV_MAP[i / 4];
			cyc(1);
			ev = 6'h00;
			cyc(1);
			check("sync start", 16'(want), RUN_FLAG);
		end
		SYNC_TRIGGER_SELECT = 3'h0;
		pulse(RUN_CLEAR_REQUEST);
		pulse(STATE_SOFT_SET);
		check("soft set", 16'h0001, COMPARE_STATE_BIT);
		pulse(STATE_SOFT_CLEAR);
		check("soft clear", 16'h0000, COMPARE_STATE_BIT);
		PASSIVE_WR = 1'b1;
		for (int i = 0; i < 32; i++) begin
			{PIN_MODULATION_ENABLE, PIN_SOURCE_STATE_SELECT, TRAP_STATE, TRAP_OUTPUT_ENABLE,
				PASSIVE_WDATA} = 5'(i);
			INTERNAL_LINE_STATE_SELECT = i[0];
			cyc(3);
			check("pin", 16'(i[0] ^ (i[4] & !i[3] & !(i[2] & i[1]))), COMPARE_OUTPUT_PIN);
			check("line", 16'(!i[0]), INTERNAL_MODULATION_LINE);
		end
		conclude();
	end
endmodule : second_timer_bench
`default_nettype wire
